// ---- core/tmr_core.sv ----
// control and count logic of two timer/counters behind special function registers
// assumes a core that issues one-cycle read, write and interrupt vector strobes on mclk
// assumes both pins are asynchronous to mclk and the count bytes are loaded elsewhere
//
// Summary of operation
// (RULE1) timer B overflow sets its flag; vectoring to its handler clears it
// (RULE2) timer A overflow sets its flag; vectoring to its handler clears it
// (RULE3) timer B counts while its run bit is one, holds otherwise
// (RULE4) timer A counts while its run bit is one, halts otherwise
// (RULE5) an active edge on the interrupt A pin sets its edge flag
// (RULE6) trigger select one means edge triggered, zero means level triggered
// (RULE7) interrupt B edge flag and trigger select do not exist; bits dead
// (RULE8) run and gating set: timer A counts only while interrupt A pin high
// (RULE9) gating clear: timer A counts whenever its run bit is one
// (RULE10) source select zero counts system clock, one counts count pin A
// (RULE11) timer B gating and source select do not exist; bits dead
// (RULE12) two-bit mode: 13-bit, 16-bit, 8-bit reload, split
// (RULE13) timer B mode sits in mode register bits five and four
// (RULE14) timer A mode sits in mode register bits one and zero
// (RULE15) split: timer A low byte counts under timer A's own controls
// (RULE16) split: timer A high byte counts under timer B run and flag
// (RULE17) timer B in split mode holds both of its count bytes
// (RULE18) reload mode: low byte counts, high byte reloads it on overflow
// (RULE19) all count bytes reset to zero
// (RULE20) one count per selected event; wrap from all ones raises overflow
// (RULE21) control register bit addressable, mode register byte access only
module tmr_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tmr_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_wdata,
  input wire logic isr_ack_timer_a,
  input wire logic isr_ack_timer_b,
  input wire logic isr_ack_ext_irq_a,
  input wire logic ext_irq_a_pin,
  input wire logic count_input_pin_a,
  output logic [7:0] sfr_rdata,
  output logic timer_a_overflow_flag,
  output logic timer_b_overflow_flag,
  output logic ext_irq_a_edge_flag,
  output logic [7:0] timer_a_low_byte,
  output logic [7:0] timer_a_high_byte,
  output logic [7:0] timer_b_low_byte,
  output logic [7:0] timer_b_high_byte
);
  import tmr_pkg::*;
  `include "tmr_regs.svh"

  localparam int SYNC_STAGES = 2;

  // the decoder and the field macros must agree with the byte layout the core expects
  if (`TMR_TC_BIT_BASE != (`TMR_TIMER_CONTROL_ADDR >> 3)) begin : g_chk_bit_base
    $error("timer_control bit window does not cover its byte address");
  end
  if ((`TMR_TIMER_CONTROL_ADDR & 8'h07) != 8'h00) begin : g_chk_bit_align
    $error("timer_control must sit on an eight-aligned address for bit access");
  end
  if (`TMR_TIMER_CONTROL_ADDR == `TMR_TIMER_MODE_ADDR) begin : g_chk_addr
    $error("timer_control and timer_mode share one address");
  end
  if (`TMR_TM_MODEB_HI != `TMR_TM_MODEB_LO + 1) begin : g_chk_modeb
    $error("timer B mode field must be two adjacent bits");
  end
  if (`TMR_TM_MODEA_HI != `TMR_TM_MODEA_LO + 1) begin : g_chk_modea
    $error("timer A mode field must be two adjacent bits");
  end
  if (`TMR_TC_TFB > 7 || `TMR_TC_TRB > 7 || `TMR_TC_TFA > 7 || `TMR_TC_TRA > 7 ||
      `TMR_TC_IEA > 7 || `TMR_TC_ITA > 7) begin : g_chk_tc_pos
    $error("timer_control field outside its byte");
  end
  if (`TMR_TM_MODEB_HI > 7 || `TMR_TM_GATEA > 7 || `TMR_TM_SRCA > 7) begin : g_chk_tm_pos
    $error("timer_mode field outside its byte");
  end

  function automatic tmr_timer_control_t timer_control_from(input logic [7:0] b);
    tmr_timer_control_t t;
    t.timer_b_overflow_flag = b[`TMR_TC_TFB];
    t.timer_b_run = b[`TMR_TC_TRB];
    t.timer_a_overflow_flag = b[`TMR_TC_TFA];
    t.timer_a_run = b[`TMR_TC_TRA];
    t.ext_irq_a_edge_flag = b[`TMR_TC_IEA];
    t.ext_irq_a_trigger_select = b[`TMR_TC_ITA];
    return t;
  endfunction

  // bits three and two have no function and read as zero
  function automatic logic [7:0] timer_control_byte(input tmr_timer_control_t t);
    logic [7:0] b;
    b = 8'h00; // RULE7
    b[`TMR_TC_TFB] = t.timer_b_overflow_flag;
    b[`TMR_TC_TRB] = t.timer_b_run;
    b[`TMR_TC_TFA] = t.timer_a_overflow_flag;
    b[`TMR_TC_TRA] = t.timer_a_run;
    b[`TMR_TC_IEA] = t.ext_irq_a_edge_flag;
    b[`TMR_TC_ITA] = t.ext_irq_a_trigger_select;
    return b;
  endfunction

  // bits seven and six have no function; they are dropped on write
  function automatic tmr_timer_mode_t timer_mode_from(input logic [7:0] b);
    tmr_timer_mode_t m;
    m.timer_b_mode = tmr_mode_t'(b[`TMR_TM_MODEB_HI:`TMR_TM_MODEB_LO]); // RULE13 RULE11
    m.timer_a_pin_gating = b[`TMR_TM_GATEA];
    m.timer_a_source_select = b[`TMR_TM_SRCA];
    m.timer_a_mode = tmr_mode_t'(b[`TMR_TM_MODEA_HI:`TMR_TM_MODEA_LO]); // RULE14
    return m;
  endfunction

  function automatic logic [7:0] timer_mode_byte(input tmr_timer_mode_t m);
    logic [7:0] b;
    b = 8'h00; // RULE11
    b[`TMR_TM_MODEB_HI:`TMR_TM_MODEB_LO] = m.timer_b_mode;
    b[`TMR_TM_GATEA] = m.timer_a_pin_gating;
    b[`TMR_TM_SRCA] = m.timer_a_source_select;
    b[`TMR_TM_MODEA_HI:`TMR_TM_MODEA_LO] = m.timer_a_mode;
    return b;
  endfunction

  // hardware set wins over a handler ack or a software clear in the same cycle
  function automatic logic flag_next(input logic set, input logic cur, input logic clr);
    return set | (cur & ~clr);
  endfunction

  // one increment of a timer pair in the given mode
  function automatic tmr_cnt_t count_step(input tmr_mode_t m, input logic [7:0] tl,
                                          input logic [7:0] th);
    tmr_cnt_t r;
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    r = '{low: tl, high: th, ovf: 1'b0};
    s13 = {1'b0, th, tl[4:0]} + 14'h0001;
    s16 = {1'b0, th, tl} + 17'h00001;
    s8 = {1'b0, tl} + 9'h001;
    case (m) // RULE12
      TMR_MODE_13BIT: begin
        // upper three low-byte bits are outside the 13-bit count and keep their value
        r.low = {tl[7:5], s13[4:0]};
        r.high = s13[12:5];
        r.ovf = s13[13]; // RULE20
      end
      TMR_MODE_16BIT: begin
        r.low = s16[7:0];
        r.high = s16[15:8];
        r.ovf = s16[16]; // RULE20
      end
      TMR_MODE_RELOAD8: begin
        r.low = s8[8] ? th : s8[7:0]; // RULE18
        r.ovf = s8[8];
      end
      TMR_MODE_SPLIT: begin
        r.low = s8[7:0]; // RULE15
        r.ovf = s8[8];
      end
      default: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction

  localparam tmr_core_state_t ST_RST = '{
    timer_control: timer_control_from(`TMR_TIMER_CONTROL_RST),
    timer_mode: timer_mode_from(`TMR_TIMER_MODE_RST),
    tl_a: `TMR_COUNT_RST,
    th_a: `TMR_COUNT_RST,
    tl_b: `TMR_COUNT_RST,
    th_b: `TMR_COUNT_RST,
    rdata: 8'h00
  };

  tmr_pin_if irq_a_sync ();
  tmr_pin_if cnt_a_sync ();
  tmr_wr_if wr ();

  tmr_pin_in #(.STAGES(SYNC_STAGES), .IDLE(1'b1)) u_irq_a_pin (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(ext_irq_a_pin),
    .sync(irq_a_sync)
  );

  // count pin idles low so a pin held low at reset is not counted
  tmr_pin_in #(.STAGES(SYNC_STAGES), .IDLE(1'b0)) u_cnt_a_pin (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(count_input_pin_a),
    .sync(cnt_a_sync)
  );

  tmr_sfr_dec u_dec (
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wdata(sfr_bit_wdata),
    .wr(wr)
  );

  tmr_core_state_t st;
  tmr_core_state_t next_st;

  always_comb begin
    logic run_a;
    logic ev_a;
    logic split_a;
    logic set_tf_a;
    logic set_tf_b;
    logic [8:0] th_split;
    logic [7:0] tc_w;
    tmr_timer_control_t tw;
    tmr_cnt_t ca;
    tmr_cnt_t cb;
    run_a = 1'b0;
    ev_a = 1'b0;
    split_a = 1'b0;
    set_tf_a = 1'b0;
    set_tf_b = 1'b0;
    th_split = 9'h000;
    tc_w = 8'h00;
    tw = '0;
    ca = '0;
    cb = '0;
    next_st = st;
    next_st.rdata = 8'h00;

    // timer A enable: run bit, optionally gated by the interrupt pin level
    run_a = st.timer_control.timer_a_run & // RULE4
            (~st.timer_mode.timer_a_pin_gating | irq_a_sync.level); // RULE8 RULE9
    ev_a = st.timer_mode.timer_a_source_select ? cnt_a_sync.fall : 1'b1; // RULE10
    split_a = st.timer_mode.timer_a_mode == TMR_MODE_SPLIT;

    ca = count_step(st.timer_mode.timer_a_mode, st.tl_a, st.th_a);
    if (run_a && ev_a) begin // RULE20
      next_st.tl_a = ca.low;
      if (!split_a) begin
        next_st.th_a = ca.high;
      end
      set_tf_a = ca.ovf;
    end

    // split: timer A high byte runs on the system clock under timer B's run bit
    th_split = {1'b0, st.th_a} + 9'h001;
    if (split_a && st.timer_control.timer_b_run) begin // RULE16
      next_st.th_a = th_split[7:0];
    end

    // timer B has no gate or source choice: it counts the system clock
    cb = count_step(st.timer_mode.timer_b_mode, st.tl_b, st.th_b);
    if (st.timer_control.timer_b_run && st.timer_mode.timer_b_mode != TMR_MODE_SPLIT) begin // RULE3 RULE17
      next_st.tl_b = cb.low;
      next_st.th_b = cb.high;
    end

    // while timer A is split its high byte owns timer B's flag
    if (split_a) begin
      set_tf_b = st.timer_control.timer_b_run & th_split[8]; // RULE16
    end else begin
      set_tf_b = st.timer_control.timer_b_run && st.timer_mode.timer_b_mode != TMR_MODE_SPLIT && cb.ovf;
    end

    // software write merged first; hardware set then wins over any clear
    tc_w = (timer_control_byte(st.timer_control) & ~wr.ctl_mask) | (wr.ctl_data & wr.ctl_mask);
    tw = timer_control_from(tc_w);
    next_st.timer_control = tw;
    next_st.timer_control.timer_b_overflow_flag = flag_next(set_tf_b, // RULE1
                                                   tw.timer_b_overflow_flag, isr_ack_timer_b);
    next_st.timer_control.timer_a_overflow_flag = flag_next(set_tf_a, // RULE2
                                                   tw.timer_a_overflow_flag, isr_ack_timer_a);
    if (st.timer_control.ext_irq_a_trigger_select) begin // RULE6
      next_st.timer_control.ext_irq_a_edge_flag = flag_next(irq_a_sync.fall, // RULE5
                                                   tw.ext_irq_a_edge_flag, isr_ack_ext_irq_a);
    end else begin
      // level mode: the flag follows the active-low pin and cannot be cleared
      next_st.timer_control.ext_irq_a_edge_flag = ~irq_a_sync.level; // RULE6
    end

    if (wr.mode_we) begin // RULE21
      next_st.timer_mode = timer_mode_from(wr.mode_data);
    end

    if (sfr_rd) begin
      case (sfr_addr)
        `TMR_TIMER_CONTROL_ADDR: next_st.rdata = timer_control_byte(st.timer_control);
        `TMR_TIMER_MODE_ADDR: next_st.rdata = timer_mode_byte(st.timer_mode);
        default: next_st.rdata = 8'h00;
      endcase
    end

    // timer reset returns every register to its power-on value
    if (tmr_rst) begin
      next_st = ST_RST; // RULE19
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RST; // RULE19
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata = st.rdata;
  assign timer_a_overflow_flag = st.timer_control.timer_a_overflow_flag;
  assign timer_b_overflow_flag = st.timer_control.timer_b_overflow_flag;
  assign ext_irq_a_edge_flag = st.timer_control.ext_irq_a_edge_flag;
  assign timer_a_low_byte = st.tl_a;
  assign timer_a_high_byte = st.th_a;
  assign timer_b_low_byte = st.tl_b;
  assign timer_b_high_byte = st.th_b;

endmodule

// ---- core/tmr_ifs.sv ----
// interfaces between the timer control top and its helper modules
// assumes all parties run on mclk
interface tmr_pin_if;
  logic level;
  logic fall;
  modport src(output level, output fall);
  modport dst(input level, input fall);
endinterface

interface tmr_wr_if;
  logic [7:0] ctl_mask;
  logic [7:0] ctl_data;
  logic mode_we;
  logic [7:0] mode_data;
  modport src(output ctl_mask, output ctl_data, output mode_we, output mode_data);
  modport dst(input ctl_mask, input ctl_data, input mode_we, input mode_data);
endinterface

// ---- core/tmr_pin_in.sv ----
// synchroniser and falling edge detector for one asynchronous input pin
// assumes the pin is unrelated to mclk
module tmr_pin_in #(
  parameter int STAGES = 2,
  parameter logic IDLE = 1'b1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pin,
  tmr_pin_if.src sync
);

  typedef struct packed {
    logic [STAGES-1:0] chain;
    logic last;
  } tmr_pin_state_t;

  tmr_pin_state_t st;
  tmr_pin_state_t next_st;

  if (STAGES < 2) begin : g_chk
    $error("tmr_pin_in needs at least two synchroniser stages");
  end

  // chain[0] is the metastable stage; only chain[1] reads it
  always_comb begin
    next_st = st;
    next_st.chain = {st.chain[STAGES-2:0], pin};
    next_st.last = st.chain[STAGES-1];
  end

  // idle level at reset keeps a quiet pin from faking an edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{chain: {STAGES{IDLE}}, last: IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign sync.level = st.chain[STAGES-1];
  assign sync.fall = st.last & ~st.chain[STAGES-1];

endmodule

// ---- core/tmr_pkg.sv ----
// types shared by the timer control block
// assumes nothing of its surroundings
package tmr_pkg;

  typedef enum logic [1:0] {
    TMR_MODE_13BIT = 2'b00,
    TMR_MODE_16BIT = 2'b01,
    TMR_MODE_RELOAD8 = 2'b10,
    TMR_MODE_SPLIT = 2'b11
  } tmr_mode_t;

  typedef struct packed {
    logic timer_b_overflow_flag;
    logic timer_b_run;
    logic timer_a_overflow_flag;
    logic timer_a_run;
    logic ext_irq_a_edge_flag;
    logic ext_irq_a_trigger_select;
  } tmr_timer_control_t;

  typedef struct packed {
    tmr_mode_t timer_b_mode;
    logic timer_a_pin_gating;
    logic timer_a_source_select;
    tmr_mode_t timer_a_mode;
  } tmr_timer_mode_t;

  // result of one count step of a timer pair
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } tmr_cnt_t;

  typedef struct packed {
    tmr_timer_control_t timer_control;
    tmr_timer_mode_t timer_mode;
    logic [7:0] tl_a;
    logic [7:0] th_a;
    logic [7:0] tl_b;
    logic [7:0] th_b;
    logic [7:0] rdata;
  } tmr_core_state_t;

endpackage

// ---- core/tmr_regs.svh ----
// register offsets, bit positions and reset values of the timer control block
// assumes byte-wide special function register addressing from the core
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

`define TMR_TIMER_CONTROL_ADDR 8'h88
`define TMR_TIMER_MODE_ADDR 8'h89
`define TMR_TIMER_CONTROL_RST 8'h00
`define TMR_TIMER_MODE_RST 8'h00
`define TMR_COUNT_RST 8'h00

// bit address window of timer_control: upper five bits of a bit address
`define TMR_TC_BIT_BASE 5'h11

// timer_control fields
`define TMR_TC_TFB 7
`define TMR_TC_TRB 6
`define TMR_TC_TFA 5
`define TMR_TC_TRA 4
`define TMR_TC_IEA 1
`define TMR_TC_ITA 0

// timer_mode fields
`define TMR_TM_MODEB_HI 5
`define TMR_TM_MODEB_LO 4
`define TMR_TM_GATEA 3
`define TMR_TM_SRCA 2
`define TMR_TM_MODEA_HI 1
`define TMR_TM_MODEA_LO 0

`endif

// ---- core/tmr_sfr_dec.sv ----
// address decode of byte and bit writes from the core
// assumes write strobes are single-cycle pulses on mclk
module tmr_sfr_dec (
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_wdata,
  tmr_wr_if.src wr
);
  `include "tmr_regs.svh"

  always_comb begin
    wr.ctl_mask = 8'h00;
    wr.ctl_data = 8'h00;
    // a byte write wins over a bit write in the same cycle
    if (sfr_wr && sfr_addr == `TMR_TIMER_CONTROL_ADDR) begin
      wr.ctl_mask = 8'hff;
      wr.ctl_data = sfr_wdata;
    end else if (sfr_bit_wr && sfr_bit_addr[7:3] == `TMR_TC_BIT_BASE) begin // RULE21
      wr.ctl_mask[sfr_bit_addr[2:0]] = 1'b1;
      wr.ctl_data = {8{sfr_bit_wdata}};
    end
    // timer_mode has no bit addresses: byte writes only
    wr.mode_we = sfr_wr && sfr_addr == `TMR_TIMER_MODE_ADDR; // RULE21
    wr.mode_data = sfr_wdata;
  end

endmodule

// ---- testbench/testbench.sv ----
// self-checking bench of the timer control block driven through a core model
// assumes the checker binds itself; inputs change on falling mclk edges
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic tmr_rst = 1'b0;
  logic ext_irq_a_pin = 1'b1;
  logic count_input_pin_a = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, q, r;
  logic sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_wdata, tfa, tfb, eflag;
  logic isr_ack_timer_a, isr_ack_timer_b, isr_ack_ext_irq_a;
  logic [7:0] tla, tha, tlb, thb;
  int fails = 0;
  int n_compared = 0;
  int n;
  always #25 mclk = ~mclk;
  tmr_cpu_model cpu_u (.mclk, .sfr_rdata, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_wdata, .isr_ack_timer_a, .isr_ack_timer_b,
    .isr_ack_ext_irq_a);
  tmr_core dut_u (.mclk, .arst_n, .tmr_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_wdata, .isr_ack_timer_a, .isr_ack_timer_b,
    .isr_ack_ext_irq_a, .ext_irq_a_pin, .count_input_pin_a, .sfr_rdata,
    .timer_a_overflow_flag(tfa), .timer_b_overflow_flag(tfb), .ext_irq_a_edge_flag(eflag),
    .timer_a_low_byte(tla), .timer_a_high_byte(tha), .timer_b_low_byte(tlb),
    .timer_b_high_byte(thb));
  // 13-bit view: five low bits in the low byte, carry into the high byte
  function automatic logic [15:0] f13(input int c);
    return {8'(c >> 5), 3'h0, 5'(c)};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cpu_u.rd(a, q);
    check({8'h00, q}, {8'h00, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic trst();
    @(negedge mclk);
    tmr_rst = 1'b1;
    @(negedge mclk);
    tmr_rst = 1'b0;
  endtask
  // the stop is a bit write so flags survive; the counter sees k+2 enabled edges
  task automatic run(input logic [7:0] tc, input logic [7:0] stop, input int k);
    cpu_u.wr(8'h88, tc);
    cyc(k);
    cpu_u.bwr(stop, 1'b0);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400us;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    void'($urandom(46));
    cyc(8);
    arst_n = 1'b1;
    check({tla, tha}, 16'h0000);
    check({tlb, thb}, 16'h0000);
    rdchk(8'h88, 8'h00);
    rdchk(8'h89, 8'h00);
    $display("test reset done");
    r = 8'($urandom);
    cpu_u.wr(8'h89, r);
    rdchk(8'h89, r & 8'h3f);
    cpu_u.wr(8'h89, 8'hff);
    rdchk(8'h89, 8'h3f);
    cpu_u.wr(8'h88, 8'h0c);
    rdchk(8'h88, 8'h00);
    cpu_u.bwr(8'h8a, 1'b1);
    rdchk(8'h88, 8'h00);
    cpu_u.bwr(8'h88, 1'b1);
    rdchk(8'h88, 8'h01);
    rdchk(8'h8e, 8'h00);
    trst();
    rdchk(8'h89, 8'h00);
    $display("test registers done");
    ext_irq_a_pin = 1'b0;
    n = 40 + $urandom_range(60);
    run(8'h10, 8'h8c, n);
    check({tha, tla}, f13(n + 2));
    cyc(5);
    check({tha, tla}, f13(n + 2));
    check({tlb, thb}, 16'h0000);
    trst();
    ext_irq_a_pin = 1'b1;
    cpu_u.wr(8'h89, 8'h10);
    n = 250 + $urandom_range(200);
    run(8'h40, 8'h8e, n);
    check({thb, tlb}, 16'(n + 2));
    cyc(5);
    check({thb, tlb}, 16'(n + 2));
    trst();
    cpu_u.wr(8'h89, 8'h01);
    n = 250 + $urandom_range(200);
    run(8'h10, 8'h8c, n);
    check({tha, tla}, 16'(n + 2));
    run(8'h40, 8'h8e, n);
    check({thb, tlb}, f13(n + 2));
    trst();
    $display("test 13 and 16 bit done");
    cpu_u.wr(8'h89, 8'h02);
    n = 260 + $urandom_range(20);
    run(8'h10, 8'h8c, n);
    check({tha, tla}, {8'h00, 8'(n + 2)});
    check({15'h0, tfa}, 16'h0001);
    cpu_u.ack(3'h1);
    check({15'h0, tfa}, 16'h0000);
    trst();
    $display("test reload done");
    cpu_u.wr(8'h89, 8'h33);
    n = 256 + $urandom_range(40);
    run(8'h40, 8'h8e, n);
    check({tha, tla}, {8'(n + 2), 8'h00});
    check({tlb, thb}, 16'h0000);
    check({14'h0, tfb, tfa}, 16'h0002);
    cpu_u.ack(3'h2);
    check({15'h0, tfb}, 16'h0000);
    run(8'h10, 8'h8c, 9);
    check({tha, tla}, {8'(n + 2), 8'h0b});
    trst();
    $display("test split done");
    cpu_u.wr(8'h89, 8'h08);
    ext_irq_a_pin = 1'b0;
    cyc(4);
    run(8'h10, 8'h8c, 20);
    check({tha, tla}, 16'h0000);
    ext_irq_a_pin = 1'b1;
    cyc(4);
    run(8'h10, 8'h8c, 20);
    check({tha, tla}, f13(22));
    trst();
    cpu_u.wr(8'h89, 8'h04);
    cpu_u.wr(8'h88, 8'h10);
    n = 3 + $urandom_range(7);
    repeat (n) begin
      count_input_pin_a = 1'b1;
      cyc(4);
      count_input_pin_a = 1'b0;
      cyc(4);
    end
    cyc(4);
    check({tha, tla}, f13(n));
    $display("test gate and source done");
    cpu_u.bwr(8'h88, 1'b1);
    ext_irq_a_pin = 1'b0;
    cyc(6);
    check({15'h0, eflag}, 16'h0001);
    cpu_u.ack(3'h4);
    cyc(4);
    check({15'h0, eflag}, 16'h0000);
    cpu_u.bwr(8'h88, 1'b0);
    cyc(4);
    check({15'h0, eflag}, 16'h0001);
    $display("test ext irq done");
    summarize();
  end
endmodule

// ---- testbench/tmr_core_chk.sv ----
// port-level assertions of the timer control block
// assumes one clock domain and the bind at the foot of this file
module tmr_core_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tmr_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic isr_ack_timer_b,
  input wire logic ext_irq_a_pin,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer_a_overflow_flag,
  input wire logic timer_b_overflow_flag,
  input wire logic ext_irq_a_edge_flag,
  input wire logic [7:0] timer_a_low_byte,
  input wire logic [7:0] timer_a_high_byte,
  input wire logic [7:0] timer_b_low_byte,
  input wire logic [7:0] timer_b_high_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  AST_RD_IDLE:
  assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("rdata not idle");
  AST_CTL_DEAD:
  assert property ($past(sfr_rd) && $past(sfr_addr) == 8'h88 |-> sfr_rdata[3:2] == 2'h0)
    else $error("dead control bits set");
  AST_MODE_DEAD:
  assert property ($past(sfr_rd) && $past(sfr_addr) == 8'h89 |-> sfr_rdata[7:6] == 2'h0)
    else $error("dead mode bits set");
  AST_RST_ZERO:
  assert property ($past(tmr_rst) |-> {timer_a_low_byte, timer_a_high_byte, timer_b_low_byte,
    timer_b_high_byte} == 32'h0 && !timer_a_overflow_flag && !timer_b_overflow_flag)
    else $error("timer reset left state");
  AST_TA_WRAP:
  assert property ($rose(timer_a_overflow_flag) && !$past(sfr_wr) && !$past(sfr_bit_wr) |->
    timer_a_low_byte[4:0] == 5'h00 || timer_a_low_byte == timer_a_high_byte)
    else $error("timer a flag without wrap");
  AST_TB_ACK:
  assert property ($past(isr_ack_timer_b) && !$past(sfr_wr || sfr_bit_wr || tmr_rst) |->
    !timer_b_overflow_flag || $past(timer_a_high_byte) == 8'hff ||
    $past(timer_b_low_byte[4:0]) == 5'h1f) else $error("timer b ack ignored");
  AST_TA_STEP:
  assert property ($changed(timer_a_low_byte) && !$past(tmr_rst) |-> timer_a_low_byte ==
    $past(timer_a_low_byte) + 8'h01 || timer_a_low_byte[4:0] == 5'h00 ||
    timer_a_low_byte == timer_a_high_byte) else $error("timer a bad step");
  AST_EXT_SET:
  assert property ($rose(ext_irq_a_edge_flag) && !$past(sfr_wr) && !$past(sfr_bit_wr) |->
    !$past(ext_irq_a_pin, 2)) else $error("ext flag without low pin");
endmodule
bind tmr_core tmr_core_chk chk_u (.mclk, .arst_n, .tmr_rst, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_bit_wr, .isr_ack_timer_b, .ext_irq_a_pin, .sfr_rdata, .timer_a_overflow_flag,
  .timer_b_overflow_flag, .ext_irq_a_edge_flag, .timer_a_low_byte, .timer_a_high_byte,
  .timer_b_low_byte, .timer_b_high_byte);

// ---- testbench/tmr_cpu_model.sv ----
// core model: byte and bit register writes, byte reads and handler acks
// assumes strobes change on falling mclk edges and the block samples on rising ones
module tmr_cpu_model (
  input wire logic mclk,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  output logic sfr_bit_wr,
  output logic [7:0] sfr_bit_addr,
  output logic sfr_bit_wdata,
  output logic isr_ack_timer_a,
  output logic isr_ack_timer_b,
  output logic isr_ack_ext_irq_a
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
    {sfr_bit_wr, sfr_bit_addr, sfr_bit_wdata} = '0;
    {isr_ack_ext_irq_a, isr_ack_timer_b, isr_ack_timer_a} = 3'h0;
  end
  // released address and data are inverted so a stale value never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask
  task automatic bwr(input logic [7:0] a, input logic b);
    @(negedge mclk);
    sfr_bit_addr = a;
    sfr_bit_wdata = b;
    sfr_bit_wr = 1'b1;
    @(negedge mclk);
    sfr_bit_wr = 1'b0;
    sfr_bit_addr = ~a;
    sfr_bit_wdata = ~b;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    q = sfr_rdata;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
  endtask
  task automatic ack(input logic [2:0] m);
    @(negedge mclk);
    {isr_ack_ext_irq_a, isr_ack_timer_b, isr_ack_timer_a} = m;
    @(negedge mclk);
    {isr_ack_ext_irq_a, isr_ack_timer_b, isr_ack_timer_a} = 3'h0;
  endtask
endmodule
